// File: design/adc_link_if.sv
interface adc_link_if;
   logic csN;
   logic sclk;
   logic mosi;
   logic miso;
   logic misoOe;
   logic misoLine;
   logic conversionStartN;
   logic eocN;

   // released line reads as pulled high
   assign misoLine = misoOe ? miso : 1'b1;

   modport device_mp (
      input csN,
      input sclk,
      input mosi,
      input conversionStartN,
      output miso,
      output misoOe,
      output eocN
   );

   modport host_mp (
      output csN,
      output sclk,
      output mosi,
      output conversionStartN,
      input misoLine,
      input eocN
   );
endinterface : adc_link_if

// File: design/adc_link_pkg.sv
package adc_link_pkg;
   // converter shape
   localparam int CHANNELS = 4;
   localparam int DATA_W = 10;
   localparam int CHAN_W = 2;
   localparam int WORD_W = CHAN_W + DATA_W;
   localparam int CMD_W = 8;
   localparam int FRAME_BITS = 16;
   localparam int PAD_W = FRAME_BITS - 1 - WORD_W;
   localparam int FIFO_DEPTH = 8;
   localparam int BIT_CNT_W = 5;
   localparam int CNT_W = 8;

   // command and result layout
   localparam int CMD_SETUP_BIT = 7;
   localparam int RESULT_VALID_BIT = 15;

   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int CONV_TIME_NS = 3000;
   localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int CNV_PULSE_NS = 100;
   localparam int CNV_PULSE_CYCLES = (CNV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_HALF_NS = 200;
   localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // reset and idle levels
   localparam logic LINE_HIGH = 1'b1;
   localparam logic [CHAN_W-1:0] CHAN_RESET = 2'h0;

   typedef logic [DATA_W-1:0] sample_t;
   typedef logic [WORD_W-1:0] word_t;
   typedef logic [FRAME_BITS-1:0] frame_t;
   typedef logic [CMD_W-1:0] cmd_t;
   typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_t;
   typedef enum logic [1:0] {HOST_IDLE, HOST_FRAME, HOST_GAP} host_state_t;
endpackage : adc_link_pkg

// File: design/adc_serial_device.sv
module adc_serial_device
   import adc_link_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   adc_link_if.device_mp link,
   input wire logic [adc_link_pkg::CHANNELS-1:0][adc_link_pkg::DATA_W-1:0] analog_inputs,
   output logic [adc_link_pkg::CHAN_W-1:0] activeChannel,
   output logic converting,
   output logic resultsPending
);
   import adc_link_pkg::*;

   typedef struct packed {
      logic [1:0] csS;
      logic [1:0] sclkS;
      logic [1:0] mosiS;
      logic [1:0] cnvS;
      logic csPrev;
      logic sclkPrev;
      // samples pass two flops like the pins, so no half-changed value is taken
      logic [CHANNELS-1:0][DATA_W-1:0] ainS0;
      logic [CHANNELS-1:0][DATA_W-1:0] ainS1;
      conv_state_t conv;
      logic [CNT_W-1:0] convCnt;
      logic [CHAN_W-1:0] chan;
      logic [CHAN_W-1:0] convChan;
      sample_t sample;
      logic pushValid;
      word_t pushData;
      logic [BIT_CNT_W-1:0] bitCnt;
      frame_t txSh;
      cmd_t rxSh;
      logic misoOut;
      logic misoOe;
      logic eocN;
      logic pending;
   } dev_state_t;

   dev_state_t q;
   dev_state_t d;

   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   word_t fifoOutData;
   logic csLow;
   logic csFall;
   logic csRise;
   logic sclkRise;
   logic sclkFall;
   frame_t resultFrame;
   logic resultWaiting;

   // edge of a synchronised pin, judged from its last two samples
   function automatic logic pin_edge(
      input logic prev,
      input logic cur,
      input logic rising
   );
      return rising ? (cur && !prev) : (!cur && prev);
   endfunction : pin_edge

   // a short frame carries no command and leaves setup alone
   function automatic logic is_setup(
      input logic [BIT_CNT_W-1:0] bits,
      input cmd_t cmd
   );
      return (bits >= BIT_CNT_W'(CMD_W)) && cmd[CMD_SETUP_BIT];
   endfunction : is_setup

   // 8-deep result queue lets the host fall behind by several samples
   fifo_buffer #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) fifo_buffer_inst (
      .ref_clk(ref_clk),
      .srst(srst),
      .inValid(q.pushValid),
      .inReady(fifoInReady),
      .inData(q.pushData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   assign csLow = !q.csS[1];
   assign csFall = pin_edge(q.csPrev, q.csS[1], 1'h0);
   assign csRise = pin_edge(q.csPrev, q.csS[1], 1'h1);
   assign sclkRise = csLow && pin_edge(q.sclkPrev, q.sclkS[1], 1'h1);
   assign sclkFall = csLow && pin_edge(q.sclkPrev, q.sclkS[1], 1'h0);
   // one result is popped per frame, taken at the select edge
   assign fifoOutReady = csFall && fifoOutValid;
   assign resultFrame = {fifoOutValid, {PAD_W{1'b0}}, fifoOutData};
   // a sample still waiting for queue space does not count as ready yet
   assign resultWaiting = q.conv == CONV_IDLE && !q.pushValid && fifoOutValid;

   always_comb begin
      d = q;

      // pins come from another domain: two flops before use
      d.csS = {q.csS[0], link.csN};
      d.sclkS = {q.sclkS[0], link.sclk};
      d.mosiS = {q.mosiS[0], link.mosi};
      d.cnvS = {q.cnvS[0], link.conversionStartN};
      d.ainS0 = analog_inputs;
      d.ainS1 = q.ainS0;
      d.csPrev = q.csS[1];
      d.sclkPrev = q.sclkS[1];

      // a finished result waits here until the queue accepts it
      if (q.pushValid && fifoInReady) begin
         d.pushValid = 1'b0;
      end

      case (q.conv)
         CONV_IDLE: begin
            // a full queue stalls the next start instead of losing a sample
            if (!q.cnvS[1] && !q.pushValid) begin
               d.conv = CONV_BUSY;
               d.convCnt = '0;
               d.convChan = q.chan;
               d.sample = q.ainS1[q.chan];
            end
         end
         CONV_BUSY: begin
            // fixed conversion time keeps throughput under the rated rate
            if (q.convCnt == CNT_W'(CONV_CYCLES - 1)) begin
               d.conv = CONV_IDLE;
               d.pushValid = 1'b1;
               d.pushData = {q.convChan, q.sample};
            end else begin
               d.convCnt = q.convCnt + 1'b1;
            end
         end
         default: begin
            d.conv = CONV_IDLE;
         end
      endcase

      // frame start: load the oldest result, drive its first bit
      if (csFall) begin
         d.bitCnt = '0;
         d.txSh = resultFrame;
         d.misoOut = resultFrame[FRAME_BITS-1];
         d.misoOe = 1'b1;
      end

      if (sclkRise) begin
         // only the leading bits of a frame form the command
         if (q.bitCnt < BIT_CNT_W'(CMD_W)) begin
            d.rxSh = {q.rxSh[CMD_W-2:0], q.mosiS[1]};
         end
         if (q.bitCnt != '1) begin
            d.bitCnt = q.bitCnt + 1'b1;
         end
      end

      // bit moves on the fall so it is steady at the host's next rise
      if (sclkFall) begin
         d.txSh = {q.txSh[FRAME_BITS-2:0], 1'b0};
         d.misoOut = q.txSh[FRAME_BITS-2];
      end

      // setup takes effect only as the frame closes, never mid-frame
      if (csRise && is_setup(q.bitCnt, q.rxSh)) begin
         d.chan = q.rxSh[CHAN_W-1:0];
      end

      if (!csLow && !csFall) begin
         d.misoOe = 1'b0;
      end

      // high while converting or being read, low once a result waits
      d.eocN = !(resultWaiting && !csLow && !csFall);
      d.pending = fifoOutValid;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q <= '0;
         // select and start rest high so no false edge follows reset
         q.csS <= '1;
         q.csPrev <= LINE_HIGH;
         q.cnvS <= '1;
         q.conv <= CONV_IDLE;
         q.chan <= CHAN_RESET;
         q.eocN <= LINE_HIGH;
      end else begin
         q <= d;
      end
   end

   assign link.miso = q.misoOut;
   assign link.misoOe = q.misoOe;
   assign link.eocN = q.eocN;
   assign activeChannel = q.chan;
   // status for the user side only, not seen on the link
   assign converting = q.conv == CONV_BUSY;
   assign resultsPending = q.pending;
endmodule : adc_serial_device

// File: design/adc_serial_host.sv
module adc_serial_host
   import adc_link_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   adc_link_if.host_mp link,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic [adc_link_pkg::CMD_W-1:0] cmdData,
   input wire logic convReq,
   output logic convReady,
   output logic rdValid,
   output logic [adc_link_pkg::FRAME_BITS-1:0] rdData
);
   import adc_link_pkg::*;

   typedef struct packed {
      host_state_t st;
      logic [1:0] misoS;
      logic [1:0] eocS;
      logic [CNT_W-1:0] div;
      logic [BIT_CNT_W-1:0] bitCnt;
      cmd_t txSh;
      frame_t rxSh;
      logic sclk;
      logic csN;
      logic mosi;
      logic cnvN;
      logic [CNT_W-1:0] cnvCnt;
      logic rdValid;
      frame_t rdData;
   } host_reg_t;

   host_reg_t q;
   host_reg_t d;
   logic halfDone;

   assign halfDone = q.div == CNT_W'(SCLK_HALF_CYCLES - 1);
   assign cmdReady = q.st == HOST_IDLE;
   assign convReady = q.cnvCnt == '0;

   always_comb begin
      d = q;
      d.misoS = {q.misoS[0], link.misoLine};
      d.eocS = {q.eocS[0], link.eocN};
      d.rdValid = 1'b0;

      // fixed-width start pulse, long enough for the far end to sample
      if (convReq && convReady) begin
         d.cnvN = 1'b0;
         d.cnvCnt = CNT_W'(CNV_PULSE_CYCLES);
      end else if (q.cnvCnt != '0) begin
         d.cnvCnt = q.cnvCnt - 1'b1;
         if (q.cnvCnt == CNT_W'(1)) begin
            d.cnvN = 1'b1;
         end
      end

      case (q.st)
         HOST_IDLE: begin
            // a command wins; otherwise read once a result is flagged
            if (cmdValid || !q.eocS[1]) begin
               d.st = HOST_FRAME;
               d.csN = 1'b0;
               d.div = '0;
               d.bitCnt = '0;
               d.txSh = cmdValid ? cmdData : '0;
               d.mosi = cmdValid ? cmdData[CMD_W-1] : 1'b0;
            end
         end
         HOST_FRAME: begin
            d.div = q.div + 1'b1;
            if (halfDone) begin
               d.div = '0;
               d.sclk = !q.sclk;
               if (!q.sclk) begin
                  d.rxSh = {q.rxSh[FRAME_BITS-2:0], q.misoS[1]};
                  d.bitCnt = q.bitCnt + 1'b1;
               end else if (q.bitCnt == BIT_CNT_W'(FRAME_BITS)) begin
                  d.st = HOST_GAP;
                  d.csN = 1'b1;
                  d.mosi = 1'b0;
                  d.rdValid = 1'b1;
                  d.rdData = q.rxSh;
               end else begin
                  // new bit well before the next rising edge
                  d.txSh = {q.txSh[CMD_W-2:0], 1'b0};
                  d.mosi = q.txSh[CMD_W-2];
               end
            end
         end
         HOST_GAP: begin
            // lets the flag settle so a read is not repeated
            d.div = q.div + 1'b1;
            if (halfDone) begin
               d.div = '0;
               d.st = HOST_IDLE;
            end
         end
         default: begin
            d.st = HOST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q <= '0;
         q.st <= HOST_IDLE;
         q.misoS <= '1;
         q.eocS <= '1;
         q.csN <= LINE_HIGH;
         q.cnvN <= LINE_HIGH;
      end else begin
         q <= d;
      end
   end

   assign link.sclk = q.sclk;
   assign link.csN = q.csN;
   assign link.mosi = q.mosi;
   assign link.conversionStartN = q.cnvN;
   assign rdValid = q.rdValid;
   assign rdData = q.rdData;
endmodule : adc_serial_host

// File: design/fifo_buffer.sv
module fifo_buffer #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PTR_W = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wrPtr;
      logic [PTR_W-1:0] rdPtr;
      logic [PTR_W:0] count;
   } fifo_state_t;

   fifo_state_t q;
   fifo_state_t d;
   logic push;
   logic pop;

   assign inReady = q.count != (PTR_W+1)'(DEPTH);
   assign outValid = q.count != '0;
   assign outData = q.mem[q.rdPtr];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wrPtr] = inData;
         d.wrPtr = (q.wrPtr == PTR_W'(DEPTH-1)) ? '0 : q.wrPtr + 1'b1;
      end
      if (pop) begin
         d.rdPtr = (q.rdPtr == PTR_W'(DEPTH-1)) ? '0 : q.rdPtr + 1'b1;
      end
      if (push && !pop) begin
         d.count = q.count + 1'b1;
      end else if (pop && !push) begin
         d.count = q.count - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : fifo_buffer

// File: tb/adc_serial_port_assertions.sv
module adc_serial_port_assertions
   import adc_link_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic csN,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   input wire logic misoOe,
   input wire logic misoLine,
   input wire logic conversionStartN,
   input wire logic eocN
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sclk_q;
   logic csN_q;
   logic [BIT_CNT_W-1:0] rises_q;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // rise count, cleared as a frame opens
   always_ff @(posedge ref_clk) begin
      sclk_q <= sclk;
      csN_q <= csN;
      if (srst || (!csN && csN_q)) begin
         rises_q <= '0;
      end else if (sclk && !sclk_q) begin
         rises_q <= rises_q + 5'h01;
      end
   end
   property p_frame_bits;
      $rose(csN) |-> rises_q == 5'h10;
   endproperty
   a_frame_bits: assert property (p_frame_bits) else $error("frame not 16 clocks");
   property p_sclk_idle;
      csN |-> !sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("clock moves unselected");
   property p_drive;
      $fell(csN) |-> ##[1:6] misoOe;
   endproperty
   a_drive: assert property (p_drive) else $error("data line not driven");
   property p_release;
      csN [*6] |-> !misoOe;
   endproperty
   a_release: assert property (p_release) else $error("data line not released");
   property p_mosi_setup;
      $rose(sclk) |-> $stable(mosi);
   endproperty
   a_mosi_setup: assert property (p_mosi_setup) else $error("input bit moves at rise");
   property p_miso_on_fall;
      (misoOe && $changed(miso)) |-> !sclk;
   endproperty
   a_miso_on_fall: assert property (p_miso_on_fall) else $error("output bit moved high");
   property p_start_pulse;
      $fell(conversionStartN) |-> !conversionStartN [*4] ##1 conversionStartN;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse length");
   // busy window and completion bound; the lower bound samples eocN high only 6 and 106 cycles after the start, not across the window
   property p_conv_eoc;
      $fell(conversionStartN) |-> ##6 eocN ##100 eocN ##[1:60] !eocN;
   endproperty
   a_conv_eoc: assert property (p_conv_eoc) else $error("end of conversion timing");
   property p_eoc_read;
      $fell(csN) |-> ##[1:6] eocN;
   endproperty
   a_eoc_read: assert property (p_eoc_read) else $error("end flag kept on read");
   c_frame: cover property ($rose(csN));
   c_conv: cover property ($fell(conversionStartN));
   c_done: cover property ($fell(eocN));
endmodule : adc_serial_port_assertions

// File: tb/adc_serial_port_test.sv
module adc_serial_port_test
   import adc_link_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk;
   logic srst;
   logic cmdValid;
   logic [CMD_W-1:0] cmdData;
   logic convReq;
   logic cmdReady;
   logic convReady;
   logic rdValid;
   logic [FRAME_BITS-1:0] rdData;
   logic [CHANNELS-1:0][DATA_W-1:0] analogInputs;
   logic [CHAN_W-1:0] activeChannel;
   logic converting;
   logic resultsPending;
   int mismatches = 0;
   int checksDone = 0;
   int cycles = 0;
   adc_link_if adc_link_if_inst();
   adc_serial_device adc_serial_device_inst (.ref_clk(ref_clk), .srst(srst),
      .link(adc_link_if_inst), .analog_inputs(analogInputs),
      .activeChannel(activeChannel), .converting(converting),
      .resultsPending(resultsPending));
   adc_serial_host adc_serial_host_inst (.ref_clk(ref_clk), .srst(srst),
      .link(adc_link_if_inst), .cmdValid(cmdValid), .cmdReady(cmdReady),
      .cmdData(cmdData), .convReq(convReq), .convReady(convReady),
      .rdValid(rdValid), .rdData(rdData));
   adc_serial_port_assertions adc_serial_port_assertions_inst (.ref_clk(ref_clk),
      .srst(srst), .csN(adc_link_if_inst.csN), .sclk(adc_link_if_inst.sclk),
      .mosi(adc_link_if_inst.mosi), .miso(adc_link_if_inst.miso),
      .misoOe(adc_link_if_inst.misoOe), .misoLine(adc_link_if_inst.misoLine),
      .conversionStartN(adc_link_if_inst.conversionStartN),
      .eocN(adc_link_if_inst.eocN));
   task automatic closeOut();
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : closeOut
   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      checksDone++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare
   // bounded wait; a missing answer is a mismatch, not a hang
   task automatic wait_read();
      int n;
      n = 0;
      while (rdValid !== 1'b1 && n < 700) begin
         @(negedge ref_clk);
         n++;
      end
      compare({15'h0000, rdValid}, 16'h0001);
   endtask : wait_read
   task automatic wait_idle();
      int n;
      n = 0;
      while ((cmdReady !== 1'b1 || convReady !== 1'b1) && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      compare({14'h0000, cmdReady, convReady}, 16'h0003);
   endtask : wait_idle
   task automatic send_cmd(input logic [CMD_W-1:0] cmd);
      wait_idle();
      cmdValid = 1'b1;
      cmdData = cmd;
      @(negedge ref_clk);
      cmdValid = 1'b0;
      wait_read();
   endtask : send_cmd
   task automatic convert(input logic [CHAN_W-1:0] ch);
      int n;
      wait_idle();
      n = 0;
      convReq = 1'b1;
      @(negedge ref_clk);
      convReq = 1'b0;
      repeat (60) @(negedge ref_clk);
      compare({15'h0000, converting}, 16'h0001);
      compare({15'h0000, adc_link_if_inst.eocN}, 16'h0001);
      // the host reads at once, so the low flag stands only a few cycles
      while (adc_link_if_inst.eocN !== 1'b0 && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      compare({15'h0000, adc_link_if_inst.eocN}, 16'h0000);
      compare({15'h0000, resultsPending}, 16'h0001);
      wait_read();
      compare(rdData, {1'b1, 3'h0, ch, analogInputs[ch]});
      @(negedge ref_clk);
      compare({15'h0000, adc_link_if_inst.eocN}, 16'h0001);
   endtask : convert
   task automatic t_channels();
      for (int i = 0; i < CHANNELS; i++) begin
         send_cmd(8'h80 | 8'(i));
         // setup lands only after select is seen high again
         repeat (4) @(negedge ref_clk);
         compare({14'h0000, activeChannel}, 16'(i));
         compare({15'h0000, rdData[15]}, 16'h0000);
         convert(2'(i));
      end
      $display("t_channels done");
   endtask : t_channels
   // no setup bit: channel must survive, fresh sample must arrive
   task automatic t_no_setup();
      analogInputs[3] = 10'h155;
      send_cmd(8'h01);
      repeat (4) @(negedge ref_clk);
      compare({14'h0000, activeChannel}, 16'h0003);
      convert(2'h3);
      $display("t_no_setup done");
   endtask : t_no_setup
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 12000) begin
         mismatches++;
         $display("BAD at %0t: run too long", $time);
         closeOut();
      end
   end
   initial begin
      srst = 1'b1;
      cmdValid = 1'b0;
      cmdData = 8'h00;
      convReq = 1'b0;
      analogInputs = {10'h3a5, 10'h05a, 10'h2c3, 10'h1e7};
      repeat (16) @(negedge ref_clk);
      srst = 1'b0;
      @(negedge ref_clk);
      t_channels();
      t_no_setup();
      closeOut();
   end
endmodule : adc_serial_port_test
